// ---- rtl/aecr_regs.vh ----
`ifndef AECR_REGS_VH
`define AECR_REGS_VH

// =====================================================
// Sizes
`define AECR_NSRC 16
`define AECR_CW 6
`define AECR_QDEPTH 8
`define AECR_ENTRY_W 42

// =====================================================
// Source indices
`define AECR_SRC_CRC0 4'h0
`define AECR_SRC_TRIG_RISE 4'h4
`define AECR_SRC_TRIG_FALL 4'h5
`define AECR_SRC_STROBE_RISE 4'h6
`define AECR_SRC_STROBE_FALL 4'h7
`define AECR_SRC_CYCLE_ALLOWED 4'h8
`define AECR_SRC_TRIG_DROPPED 4'h9
`define AECR_SRC_TRIG_DEFERRED 4'hA
`define AECR_SRC_LINK_ACKED 4'hB
`define AECR_SRC_LINK_RETX 4'hC
`define AECR_SRC_SCAN_BEGIN 4'hD
`define AECR_SRC_SCAN_FINISH 4'hE
`define AECR_SRC_FRAME_REFUSED 4'hF

// =====================================================
// Defined cause bit positions per source
`define AECR_MASK_DROPPED 6'h0F
`define AECR_MASK_DEFERRED 6'h03
`define AECR_MASK_SCAN_BEGIN 6'h0E
`define AECR_MASK_SCAN_FINISH 6'h3E
`define AECR_MASK_REFUSED 6'h03

// =====================================================
// Reset values
`define AECR_EN_RST 16'h0000
`define AECR_CNT_RST 32'h0000_0000

`endif

// ---- rtl/aecr_cnt.v ----
`include "aecr_regs.vh"
`default_nettype none
module aecr_cnt (
  input wire clk,
  input wire arst_n,
  input wire inc,
  input wire clr,
  output reg [31:0] cnt_q
);

  // Clear and count in one cycle: the event is still counted
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= `AECR_CNT_RST;
    end else if (clr) begin
      cnt_q <= {31'h0000_0000, inc};
    end else if (inc) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/aecr_top.v ----
`include "aecr_regs.vh"
`default_nettype none
module aecr_top (
  input wire clk,
  input wire arst_n,
  input wire [3:0] link_crc_fail_conn,
  input wire trig_out_lvl,
  input wire strobe_out_lvl,
  input wire cycle_allowed_pls,
  input wire trig_dropped_pls,
  input wire [3:0] trig_dropped_cause,
  input wire trig_deferred_pls,
  input wire [1:0] trig_deferred_cause,
  input wire link_trig_acked_pls,
  input wire link_trig_retx_pls,
  input wire scan_begin_pls,
  input wire [5:0] scan_begin_cause,
  input wire scan_finish_pls,
  input wire [5:0] scan_finish_cause,
  input wire frame_refused_pls,
  input wire [1:0] frame_refused_cause,
  input wire notify_wr,
  input wire [15:0] notify_wdata,
  output reg [15:0] notify_en_q,
  input wire cnt_clr_one,
  input wire [3:0] cnt_clr_sel,
  input wire cnt_clr_all,
  input wire [3:0] cnt_rd_sel,
  output reg [31:0] cnt_rd_data_q,
  input wire evt_rd,
  output reg evt_signaled_q,
  output reg [3:0] evt_src_q,
  output reg [5:0] evt_cause_q,
  output reg [31:0] evt_count_q,
  input wire merged_clr,
  output reg merged_q
);

  // =====================================================
  // Helpers
  function [5:0] cause_mask;
    input [3:0] src;
    begin
      case (src)
        `AECR_SRC_TRIG_DROPPED: cause_mask = `AECR_MASK_DROPPED;
        `AECR_SRC_TRIG_DEFERRED: cause_mask = `AECR_MASK_DEFERRED;
        `AECR_SRC_SCAN_BEGIN: cause_mask = `AECR_MASK_SCAN_BEGIN;
        `AECR_SRC_SCAN_FINISH: cause_mask = `AECR_MASK_SCAN_FINISH;
        `AECR_SRC_FRAME_REFUSED: cause_mask = `AECR_MASK_REFUSED;
        default: cause_mask = 6'h00;
      endcase
    end
  endfunction

  // Lowest index wins; bit 4 flags that anything was found
  function [4:0] first_set;
    input [15:0] v;
    integer k;
    begin
      first_set = 5'h00;
      for (k = 15; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = {1'b1, k[3:0]};
        end
      end
    end
  endfunction

  // =====================================================
  // Edge detection on the controller's own outputs
  reg trig_prev_q;
  reg strobe_prev_q;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_prev_q <= 1'b0;
      strobe_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_out_lvl;
      strobe_prev_q <= strobe_out_lvl;
    end
  end

  // =====================================================
  // Event vector
  wire [15:0] ev;
  assign ev[3:0] = link_crc_fail_conn;
  assign ev[4] = trig_out_lvl & ~trig_prev_q;
  assign ev[5] = ~trig_out_lvl & trig_prev_q;
  assign ev[6] = strobe_out_lvl & ~strobe_prev_q;
  assign ev[7] = ~strobe_out_lvl & strobe_prev_q;
  assign ev[8] = cycle_allowed_pls;
  assign ev[9] = trig_dropped_pls;
  assign ev[10] = trig_deferred_pls;
  assign ev[11] = link_trig_acked_pls;
  assign ev[12] = link_trig_retx_pls;
  assign ev[13] = scan_begin_pls;
  assign ev[14] = scan_finish_pls;
  assign ev[15] = frame_refused_pls;

  wire [95:0] cause_raw;
  assign cause_raw[53:0] = 54'h0;
  assign cause_raw[59:54] = {2'b00, trig_dropped_cause};
  assign cause_raw[65:60] = {4'h0, trig_deferred_cause};
  assign cause_raw[77:66] = 12'h000;
  assign cause_raw[83:78] = scan_begin_cause;
  assign cause_raw[89:84] = scan_finish_cause;
  assign cause_raw[95:90] = {4'h0, frame_refused_cause};

  // =====================================================
  // Occurrence counters, blind to the notification mask
  wire [511:0] cnt_flat;
  wire [15:0] clr_vec;
  assign clr_vec = {16{cnt_clr_all}} | (cnt_clr_one ? (16'h0001 << cnt_clr_sel) : 16'h0000);

  genvar g;
  generate
    for (g = 0; g < `AECR_NSRC; g = g + 1) begin : g_cnt
      aecr_cnt u_cnt (
        .clk(clk),
        .arst_n(arst_n),
        .inc(ev[g]),
        .clr(clr_vec[g]),
        .cnt_q(cnt_flat[g*32 +: 32])
      );
    end
  endgenerate

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_rd_data_q <= `AECR_CNT_RST;
    end else begin
      cnt_rd_data_q <= cnt_flat[{cnt_rd_sel, 5'b00000} +: 32];
    end
  end

  // =====================================================
  // Notification filter
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      notify_en_q <= `AECR_EN_RST;
    end else if (notify_wr) begin
      notify_en_q <= notify_wdata;
    end
  end

  // =====================================================
  // Pending stage: several sources may fire in one cycle,
  // the queue takes one entry per cycle
  reg [15:0] pend_q;
  reg [5:0] cause_q [0:15];
  wire [15:0] fire;
  wire [4:0] pick;
  wire push;
  wire [15:0] push_oh;
  reg [3:0] fill_q;

  assign fire = ev & notify_en_q;
  assign pick = first_set(pend_q);
  assign push = pick[4] & (fill_q != 4'h8);
  assign push_oh = push ? (16'h0001 << pick[3:0]) : 16'h0000;

  integer i;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        cause_q[i] <= 6'h00;
      end
    end else begin
      // A new firing beats the drain of the same source
      pend_q <= (pend_q & ~push_oh) | fire;
      for (i = 0; i < 16; i = i + 1) begin
        if (fire[i]) begin
          cause_q[i] <= cause_raw[i*6 +: 6] & cause_mask(i[3:0]);
        end
      end
    end
  end

  // Refire on a still-pending source collapses into one entry
  wire merged_set;
  assign merged_set = |(fire & pend_q & ~push_oh);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      merged_q <= 1'b0;
    end else if (merged_set) begin
      merged_q <= 1'b1;
    end else if (merged_clr) begin
      merged_q <= 1'b0;
    end
  end

  // =====================================================
  // Event queue
  reg [41:0] mem_q [0:7];
  reg [2:0] wr_ptr_q;
  reg [2:0] rd_ptr_q;
  wire pop;
  wire [41:0] push_entry;
  wire [3:0] fill_d;
  wire [2:0] rd_ptr_d;
  wire [41:0] head_d;

  assign pop = evt_rd & evt_signaled_q;
  assign push_entry = {pick[3:0], cause_q[pick[3:0]], cnt_flat[{pick[3:0], 5'b00000} +: 32]};
  assign fill_d = fill_q + {3'b000, push} - {3'b000, pop};
  assign rd_ptr_d = rd_ptr_q + {2'b00, pop};
  // Head shown is that of the next state, so reads may run back to back
  assign head_d = (fill_q == {3'b000, pop}) ? push_entry : mem_q[rd_ptr_d];

  integer j;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_q <= 3'h0;
      rd_ptr_q <= 3'h0;
      fill_q <= 4'h0;
      for (j = 0; j < 8; j = j + 1) begin
        mem_q[j] <= 42'h0;
      end
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= push_entry;
        wr_ptr_q <= wr_ptr_q + 3'h1;
      end
      rd_ptr_q <= rd_ptr_d;
      fill_q <= fill_d;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_signaled_q <= 1'b0;
      evt_src_q <= 4'h0;
      evt_cause_q <= 6'h00;
      evt_count_q <= `AECR_CNT_RST;
    end else begin
      evt_signaled_q <= (fill_d != 4'h0);
      evt_src_q <= head_d[41:38];
      evt_cause_q <= head_d[37:32];
      evt_count_q <= head_d[31:0];
    end
  end

endmodule
`default_nettype wire

// ---- sim/aecr_top_sva.sv ----
`default_nettype none
module aecr_top_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic trig_out_lvl,
  input wire logic notify_wr,
  input wire logic [15:0] notify_wdata,
  input wire logic [15:0] notify_en_q,
  input wire logic evt_rd,
  input wire logic evt_signaled_q,
  input wire logic [3:0] evt_src_q,
  input wire logic [5:0] evt_cause_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Trigger edge events reach an empty queue
  sequence rise_s;
    $rose(trig_out_lvl) && notify_en_q[4] && !evt_signaled_q;
  endsequence
  sequence fall_s;
    $fell(trig_out_lvl) && notify_en_q[5] && !evt_signaled_q;
  endsequence
  rise_evt_a: assert property (rise_s |-> ##2 evt_signaled_q) else $error("no rise entry");
  fall_evt_a: assert property (fall_s |-> ##2 evt_signaled_q) else $error("no fall entry");
  // ==========================================
  // Queue and mask
  head_hold_a: assert property (evt_signaled_q && !evt_rd |=> evt_signaled_q &&
    $stable({evt_src_q, evt_cause_q})) else $error("head moved");
  mask_wr_a: assert property (notify_wr |=> notify_en_q == $past(notify_wdata))
    else $error("mask not written");
  // Stale pending entries have drained after three masked cycles
  quiet_a: assert property ((notify_en_q == 16'h0000) [*3] ##0 !evt_signaled_q |=>
    !evt_signaled_q) else $error("masked entry");
  // ==========================================
  // Cause fields
  nocause_a: assert property (evt_signaled_q && evt_src_q < 4'h9 |-> evt_cause_q == 6'h00)
    else $error("cause on plain source");
  drop_cause_a: assert property (evt_src_q == 4'h9 |-> evt_cause_q[5:4] == 2'h0)
    else $error("drop cause");
  two_cause_a: assert property (evt_src_q == 4'hA || evt_src_q == 4'hF |->
    evt_cause_q[5:2] == 4'h0) else $error("two bit cause");
  sbeg_cause_a: assert property (evt_src_q == 4'hD |-> evt_cause_q[0] == 1'b0 &&
    evt_cause_q[5:4] == 2'h0) else $error("scan begin cause");
  sfin_cause_a: assert property (evt_src_q == 4'hE |-> evt_cause_q[0] == 1'b0)
    else $error("scan finish cause");
endmodule
bind aecr_top aecr_top_sva u_sva (.clk(clk), .arst_n(arst_n), .trig_out_lvl(trig_out_lvl),
  .notify_wr(notify_wr), .notify_wdata(notify_wdata), .notify_en_q(notify_en_q),
  .evt_rd(evt_rd), .evt_signaled_q(evt_signaled_q), .evt_src_q(evt_src_q),
  .evt_cause_q(evt_cause_q));
`default_nettype wire

// ---- sim/aecr_top_tb.sv ----
`default_nettype none
module aecr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, arst_n = 0, trig = 0, stb = 0, nwr = 0, rd = 0, c1 = 0, call = 0, mclr = 0;
  logic [15:0] ev = 0, nwd = 0;
  logic [5:0] cz = 0;
  logic [3:0] csel = 0;
  wire [15:0] en;
  wire [31:0] cnt, ecnt;
  wire sig, mq;
  wire [3:0] src;
  wire [5:0] cause;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  // One pulse vector feeds all sources except the four edge sources, which come from trig and stb; one cause bus feeds all cause ports
  aecr_top DUT (.clk(clk), .arst_n(arst_n), .link_crc_fail_conn(ev[3:0]), .trig_out_lvl(trig),
    .strobe_out_lvl(stb), .cycle_allowed_pls(ev[8]), .trig_dropped_pls(ev[9]),
    .trig_dropped_cause(cz[3:0]), .trig_deferred_pls(ev[10]), .trig_deferred_cause(cz[1:0]),
    .link_trig_acked_pls(ev[11]), .link_trig_retx_pls(ev[12]), .scan_begin_pls(ev[13]),
    .scan_begin_cause(cz), .scan_finish_pls(ev[14]), .scan_finish_cause(cz),
    .frame_refused_pls(ev[15]), .frame_refused_cause(cz[1:0]), .notify_wr(nwr),
    .notify_wdata(nwd), .notify_en_q(en), .cnt_clr_one(c1), .cnt_clr_sel(csel),
    .cnt_clr_all(call), .cnt_rd_sel(csel), .cnt_rd_data_q(cnt), .evt_rd(rd),
    .evt_signaled_q(sig), .evt_src_q(src), .evt_cause_q(cause), .evt_count_q(ecnt),
    .merged_clr(mclr), .merged_q(mq));
  initial forever #2 clk = ~clk;
  task close_out;
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out;
    end
  end
  task chk(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task tick(int n = 1);
    repeat (n) @(negedge clk);
  endtask
  task fire(int i);
    ev[i] = 1;
    if (i == 4) trig = 1;
    if (i == 5) trig = 0;
    if (i == 6) stb = 1;
    if (i == 7) stb = 0;
    tick;
    ev = 0;
  endtask
  task pop(int s, logic [5:0] c, logic [31:0] n);
    for (int k = 0; k < 20 && sig !== 1'b1; k++) tick;
    chk("src", src, s);
    chk("cause", cause, c);
    chk("count", ecnt, n);
    rd = 1;
    tick;
    rd = 0;
  endtask
  task rdcnt(int s, logic [31:0] e);
    csel = s;
    tick(2);
    chk("cnt", cnt, e);
  endtask
  task setmask(logic [15:0] m);
    nwd = m;
    nwr = 1;
    tick;
    nwr = 0;
  endtask
  // ==========================================
  // Scenarios
  task t_reset;
    chk("en", en, 0);
    chk("sig", sig, 0);
    rdcnt(8, 0);
  endtask
  task t_each;
    logic [5:0] m;
    setmask(16'hFFFF);
    for (int p = 0; p < 2; p++) begin
      // Two patterns so a swapped cause bit shows up
      cz = p ? 6'h15 : 6'h3F;
      for (int i = 0; i < 16; i++) begin
        case (i)
          9: m = 6'h0F;
          10, 15: m = 6'h03;
          13: m = 6'h0E;
          14: m = 6'h3E;
          default: m = 6'h00;
        endcase
        fire(i);
        pop(i, cz & m, p + 1);
      end
    end
  endtask
  task t_quiet;
    setmask(0);
    ev[8] = 1;
    tick(3);
    ev = 0;
    tick(4);
    chk("sig", sig, 0);
    rdcnt(8, 5);
    csel = 8;
    c1 = 1;
    tick;
    c1 = 0;
    rdcnt(8, 0);
    rdcnt(9, 2);
    call = 1;
    tick;
    call = 0;
    rdcnt(9, 0);
  endtask
  task t_pair;
    setmask(16'h1800);
    ev[11] = 1;
    ev[12] = 1;
    tick;
    ev = 0;
    pop(11, 0, 1);
    chk("sig", sig, 1);
    tick;
    pop(12, 0, 1);
    chk("sig", sig, 0);
    tick;
    rd = 1;
    tick;
    rd = 0;
    chk("sig", sig, 0);
  endtask
  task t_merge;
    setmask(16'hFFFF);
    // Twelve sources at once: eight fill the queue, four stay pending
    ev = 16'hFF0F;
    tick;
    ev = 0;
    tick(9);
    chk("merged", mq, 0);
    ev[15] = 1;
    tick;
    ev = 0;
    chk("merged", mq, 1);
    mclr = 1;
    tick;
    mclr = 0;
    chk("merged", mq, 0);
    pop(0, 0, 1);
  endtask
  initial begin
    tick(16);
    arst_n = 1;
    tick;
    t_reset;
    t_each;
    t_quiet;
    t_pair;
    t_merge;
    close_out;
  end
endmodule
`default_nettype wire
